//--- design/rftf_formatter.sv
// Contract
// - each line opens with asterisk; semicolon closes payload before trailer
// - payload goes out as hex characters, high nibble first
// - bytes pass through unchecked, no validation of any kind
// - trailer in parentheses, comma separated, line ends CR LF
// - strength signed decimal dBm, quality decimal dB
// - first timestamp: hex nanoseconds since last pulse edge
// - second timestamp: hex nanoseconds since midnight
// - timestamps only while pulse input is live, else left empty
// - short frame carries 7 bytes, long frame 14 bytes
// - every A/C reply goes out as four octal digits
// - A/C word bits 15, 11, 7, 3 are zero
// - UAT frames including uplink go out in same hex form
// - UAT trailer: strength, corrected errors, pulse timestamp only
`timescale 1ns/1ns
module rftf_formatter
    import rftf_pkg::*;
#(
    parameter int PPS_TIMEOUT = PPS_TIMEOUT_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire rftf_byte_t in_byte_i,
    input  wire logic       in_valid_i,
    output logic            in_ready_o,
    input  wire logic       pulse_per_second_input_i,
    input  wire logic       midnight_zero_i,
    output logic [7:0]      out_char_o,
    output logic            out_valid_o,
    input  wire logic       out_ready_i,
    output logic            ts_valid_o
);
    function automatic logic [7:0] hex_ch(input logic [3:0] n);
        hex_ch = (n < 4'hA) ? CH_ZERO + {4'h0, n} : CH_A + {4'h0, n} - 8'h0A;
    endfunction : hex_ch

    // {emit, char} for one step of an unpadded decimal field
    function automatic logic [8:0] dec_step(input logic [7:0] mag, input logic neg, input logic [3:0] sub);
        logic [7:0] h;
        logic [7:0] t;
        logic [7:0] u;
        h = mag / 8'h64;
        t = (mag / 8'h0A) % 8'h0A;
        u = mag % 8'h0A;
        unique case (sub)
            4'h0:    dec_step = {neg, CH_MINUS};
            4'h1:    dec_step = {h != 8'h00, CH_ZERO + h};
            4'h2:    dec_step = {(h != 8'h00) || (t != 8'h00), CH_ZERO + t};
            4'h3:    dec_step = {1'b1, CH_ZERO + u};
            default: dec_step = {1'b1, CH_COMMA};
        endcase
    endfunction : dec_step

    // {emit, char} for one hex digit with leading zeros dropped
    function automatic logic [8:0] hex_step(input logic [47:0] v, input logic [3:0] idx, input logic lead,
                                            input logic last, input logic ok);
        logic [3:0] d;
        d = v[{idx, 2'b00} +: 4];
        hex_step = {ok && (lead || d != 4'h0 || last), hex_ch(d)};
    endfunction : hex_step

    // reset release synchroniser
    logic rst_meta_r;
    logic rst_sync_r;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // pin synchronisers, pulse and midnight inputs are asynchronous
    logic [1:0] pps_sr_r;
    logic [1:0] mid_sr_r;
    logic       pps_prev_r;
    always_ff @(posedge clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            pps_sr_r   <= 2'h0;
            mid_sr_r   <= 2'h0;
            pps_prev_r <= 1'b0;
        end else begin
            pps_sr_r   <= {pps_sr_r[0], pulse_per_second_input_i};
            mid_sr_r   <= {mid_sr_r[0], midnight_zero_i};
            pps_prev_r <= pps_sr_r[1];
        end
    end

    // free-running time counters
    logic [31:0] ts1_r, ts1_nxt;
    logic [47:0] tod_r, tod_nxt;
    logic [31:0] age_r, age_nxt;
    logic        lock_r, lock_nxt;
    logic        pps_edge;
    always_comb begin
        pps_edge = pps_sr_r[1] && !pps_prev_r;
        ts1_nxt  = pps_edge ? 32'h0 : ts1_r + 32'(CLK_NS);
        age_nxt  = pps_edge ? 32'h0 : ((age_r >= 32'(PPS_TIMEOUT)) ? age_r : age_r + 32'h1);
        lock_nxt = pps_edge ? 1'b1 : ((age_r >= 32'(PPS_TIMEOUT)) ? 1'b0 : lock_r);
        tod_nxt  = tod_r + 48'(CLK_NS);
        if (tod_nxt >= DAY_NS) begin
            tod_nxt = tod_nxt - DAY_NS;
        end
        if (mid_sr_r[1]) begin
            tod_nxt = 48'h0;
        end
    end
    always_ff @(posedge clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            ts1_r  <= 32'h0;
            tod_r  <= 48'h0;
            age_r  <= 32'h0;
            lock_r <= 1'b0;
        end else begin
            ts1_r  <= ts1_nxt;
            tod_r  <= tod_nxt;
            age_r  <= age_nxt;
            lock_r <= lock_nxt;
        end
    end

    // one-byte input holding stage; ready only while it is empty
    rftf_byte_t hold_r, hold_nxt;
    logic       hold_v_r, hold_v_nxt;
    logic       in_rdy_r, in_rdy_nxt;
    logic       take;
    always_comb begin
        hold_nxt   = hold_r;
        hold_v_nxt = hold_v_r && !take;
        if (in_valid_i && in_rdy_r) begin
            hold_nxt   = in_byte_i;
            hold_v_nxt = 1'b1;
        end
        in_rdy_nxt = !hold_v_nxt;
    end
    always_ff @(posedge clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            hold_r   <= '0;
            hold_v_r <= 1'b0;
            in_rdy_r <= 1'b0;
        end else begin
            hold_r   <= hold_nxt;
            hold_v_r <= hold_v_nxt;
            in_rdy_r <= in_rdy_nxt;
        end
    end

    // line sequencer
    rftf_state_t st_r, st_nxt;
    rftf_hdr_t   hdr_r, hdr_nxt;
    logic [31:0] cap1_r, cap1_nxt;
    logic [47:0] cap2_r, cap2_nxt;
    logic        capok_r, capok_nxt;
    logic [3:0]  sub_r, sub_nxt;
    logic        lead_r, lead_nxt;
    logic        nib_r, nib_nxt;
    logic [9:0]  cnt_r, cnt_nxt;
    logic        emit, fin, go, room, uat, done;
    logic [7:0]  ch, pay, mag;
    logic [8:0]  step;
    rftf_state_t nst;
    always_comb begin
        st_nxt    = st_r;
        hdr_nxt   = hdr_r;
        cap1_nxt  = cap1_r;
        cap2_nxt  = cap2_r;
        capok_nxt = capok_r;
        sub_nxt   = sub_r;
        lead_nxt  = lead_r;
        nib_nxt   = nib_r;
        cnt_nxt   = cnt_r;
        take      = 1'b0;
        emit      = 1'b0;
        fin       = 1'b0;
        ch        = CH_ZERO;
        nst       = st_r;
        step      = 9'h0;
        uat       = hdr_r.kind == RFTF_UAT;
        // A/C octal digits come out as hex of the masked word
        pay = (hdr_r.kind == RFTF_AC) ? (hold_r.data & AC_OCTAL_MASK) : hold_r.data;
        mag = hdr_r.signal_strength_field[7] ? 8'(-hdr_r.signal_strength_field) : hdr_r.signal_strength_field;
        unique case (hdr_r.kind)
            RFTF_SHORT: done = cnt_r + 10'h1 == SHORT_BYTES;
            RFTF_LONG:  done = cnt_r + 10'h1 == LONG_BYTES;
            RFTF_AC:    done = cnt_r + 10'h1 == AC_BYTES;
            RFTF_UAT:   done = hold_r.last;
        endcase
        unique case (st_r)
            ST_IDLE: begin
                // stray bytes outside a frame are dropped, no checking at all
                if (hold_v_r && !hold_r.first) begin
                    take = 1'b1;
                end
                if (hold_v_r && hold_r.first) begin
                    hdr_nxt   = hold_r.hdr;
                    cap1_nxt  = ts1_r;
                    cap2_nxt  = tod_r;
                    capok_nxt = lock_r;
                    cnt_nxt   = 10'h0;
                    nib_nxt   = 1'b0;
                    st_nxt    = ST_STAR;
                end
            end
            ST_STAR:  begin emit = 1'b1; ch = CH_STAR;  fin = 1'b1; nst = ST_PAY;  end
            ST_PAY: begin
                emit = hold_v_r;
                ch   = hex_ch(nib_r ? pay[3:0] : pay[7:4]);
                fin  = hold_v_r && nib_r && done;
                nst  = ST_SEMI;
            end
            ST_SEMI:  begin emit = 1'b1; ch = CH_SEMI;  fin = 1'b1; nst = ST_OPEN; end
            ST_OPEN:  begin emit = 1'b1; ch = CH_OPEN;  fin = 1'b1; nst = ST_SS;   end
            ST_SS: begin
                step = dec_step(mag, hdr_r.signal_strength_field[7], sub_r);
                fin  = sub_r == DEC_COMMA_SUB;
                nst  = ST_SQ;
            end
            ST_SQ: begin
                step = dec_step(hdr_r.signal_quality_field, 1'b0, sub_r);
                fin  = sub_r == DEC_COMMA_SUB;
                nst  = ST_TS1;
            end
            ST_TS1: begin
                if (sub_r == TS1_DIGITS) begin
                    step = {!uat, CH_COMMA};
                end else begin
                    step = hex_step({16'h0, cap1_r}, TS1_DIGITS - 4'h1 - sub_r, lead_r,
                                    sub_r == TS1_DIGITS - 4'h1, capok_r);
                end
                fin = sub_r == TS1_DIGITS;
                nst = uat ? ST_CLOSE : ST_TS2;
            end
            ST_TS2: begin
                step = hex_step(cap2_r, TS24_DIGITS - 4'h1 - sub_r, lead_r,
                                sub_r == TS24_DIGITS - 4'h1, capok_r);
                fin  = sub_r == TS24_DIGITS - 4'h1;
                nst  = ST_CLOSE;
            end
            ST_CLOSE: begin emit = 1'b1; ch = CH_CLOSE; fin = 1'b1; nst = ST_CR;   end
            ST_CR:    begin emit = 1'b1; ch = CH_CR;    fin = 1'b1; nst = ST_LF;   end
            ST_LF:    begin emit = 1'b1; ch = CH_LF;    fin = 1'b1; nst = ST_IDLE; end
            default:  begin fin = 1'b1; nst = ST_IDLE; end
        endcase
        if (st_r inside {ST_SS, ST_SQ, ST_TS1, ST_TS2}) begin
            emit = step[8];
            ch   = step[7:0];
        end
        // a stalled buffer freezes the sequencer, nothing is lost
        go = (st_r != ST_IDLE) && (!emit || room);
        if (go) begin
            lead_nxt = lead_r || emit;
            sub_nxt  = sub_r + 4'h1;
            if (st_r == ST_PAY && hold_v_r) begin
                nib_nxt = !nib_r;
                take    = nib_r;
                cnt_nxt = nib_r ? cnt_r + 10'h1 : cnt_r;
            end
            if (fin) begin
                st_nxt   = nst;
                sub_nxt  = 4'h0;
                lead_nxt = 1'b0;
            end
        end
    end
    always_ff @(posedge clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            st_r    <= ST_IDLE;
            hdr_r   <= '0;
            cap1_r  <= 32'h0;
            cap2_r  <= 48'h0;
            capok_r <= 1'b0;
            sub_r   <= 4'h0;
            lead_r  <= 1'b0;
            nib_r   <= 1'b0;
            cnt_r   <= 10'h0;
        end else begin
            st_r    <= st_nxt;
            hdr_r   <= hdr_nxt;
            cap1_r  <= cap1_nxt;
            cap2_r  <= cap2_nxt;
            capok_r <= capok_nxt;
            sub_r   <= sub_nxt;
            lead_r  <= lead_nxt;
            nib_r   <= nib_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // two-entry character buffer, output data and valid registered
    logic [7:0] mem_r [2];
    logic [7:0] mem_nxt [2];
    logic       wp_r, wp_nxt, rp_r, rp_nxt;
    logic [1:0] fcnt_r, fcnt_nxt;
    logic       push, pop;
    logic [7:0] oc_r, oc_nxt;
    logic       ov_r, ov_nxt;
    always_comb begin
        room     = fcnt_r != 2'h2;
        push     = go && emit;
        pop      = ov_r && out_ready_i;
        mem_nxt  = mem_r;
        wp_nxt   = wp_r ^ push;
        rp_nxt   = rp_r ^ pop;
        fcnt_nxt = fcnt_r + {1'b0, push} - {1'b0, pop};
        if (push) begin
            mem_nxt[wp_r] = ch;
        end
        oc_nxt = mem_nxt[rp_nxt];
        ov_nxt = fcnt_nxt != 2'h0;
    end
    always_ff @(posedge clk_i or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            mem_r  <= '{8'h00, 8'h00};
            wp_r   <= 1'b0;
            rp_r   <= 1'b0;
            fcnt_r <= 2'h0;
            oc_r   <= 8'h00;
            ov_r   <= 1'b0;
        end else begin
            mem_r  <= mem_nxt;
            wp_r   <= wp_nxt;
            rp_r   <= rp_nxt;
            fcnt_r <= fcnt_nxt;
            oc_r   <= oc_nxt;
            ov_r   <= ov_nxt;
        end
    end

    assign out_char_o  = oc_r;
    assign out_valid_o = ov_r;
    assign in_ready_o  = in_rdy_r;
    assign ts_valid_o  = lock_r;
endmodule : rftf_formatter

//--- design/rftf_pkg.sv
package rftf_pkg;
    // clock and timing
    localparam int          CLK_HZ          = 25_000_000;
    localparam int          CLK_NS          = 1_000_000_000 / CLK_HZ;
    localparam int          PPS_TIMEOUT_MS  = 1500;
    localparam int          PPS_TIMEOUT_CYC = PPS_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam logic [47:0] DAY_NS          = 48'h4E94_914F_0000;
    // payload lengths in bytes, A/C mask, field digit counts
    localparam logic [9:0]  SHORT_BYTES     = 10'h007;
    localparam logic [9:0]  LONG_BYTES      = 10'h00E;
    localparam logic [9:0]  AC_BYTES        = 10'h002;
    localparam logic [7:0]  AC_OCTAL_MASK   = 8'h77;
    localparam logic [3:0]  TS1_DIGITS      = 4'h8;
    localparam logic [3:0]  TS24_DIGITS     = 4'hC;
    localparam logic [3:0]  DEC_COMMA_SUB   = 4'h4;
    // ascii
    localparam logic [7:0]  CH_STAR  = 8'h2A;
    localparam logic [7:0]  CH_SEMI  = 8'h3B;
    localparam logic [7:0]  CH_OPEN  = 8'h28;
    localparam logic [7:0]  CH_CLOSE = 8'h29;
    localparam logic [7:0]  CH_COMMA = 8'h2C;
    localparam logic [7:0]  CH_MINUS = 8'h2D;
    localparam logic [7:0]  CH_ZERO  = 8'h30;
    localparam logic [7:0]  CH_A     = 8'h41;
    localparam logic [7:0]  CH_CR    = 8'h0D;
    localparam logic [7:0]  CH_LF    = 8'h0A;

    typedef enum logic [1:0] {
        RFTF_SHORT = 2'h0,
        RFTF_LONG  = 2'h1,
        RFTF_AC    = 2'h2,
        RFTF_UAT   = 2'h3
    } rftf_kind_t;

    typedef struct packed {
        rftf_kind_t         kind;
        logic signed [7:0]  signal_strength_field;
        logic [7:0]         signal_quality_field;
    } rftf_hdr_t;

    typedef struct packed {
        rftf_hdr_t   hdr;
        logic        first;
        logic        last;
        logic [7:0]  data;
    } rftf_byte_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_STAR  = 4'h1,
        ST_PAY   = 4'h3,
        ST_SEMI  = 4'h2,
        ST_OPEN  = 4'h6,
        ST_SS    = 4'h7,
        ST_SQ    = 4'h5,
        ST_TS1   = 4'h4,
        ST_TS2   = 4'hC,
        ST_CLOSE = 4'hD,
        ST_CR    = 4'hF,
        ST_LF    = 4'hE
    } rftf_state_t;
endpackage : rftf_pkg

//--- tb/rftf_checker.sv
`timescale 1ns/1ns
module rftf_checker
    import rftf_pkg::*;
#(
    parameter int PPS_TIMEOUT = 200
) (
    input wire logic       clk_i,
    input wire logic       rst_b_i,
    input wire logic       in_valid_i,
    input wire logic       in_ready_o,
    input wire logic       pulse_per_second_input_i,
    input wire logic [7:0] out_char_o,
    input wire logic       out_valid_o,
    input wire logic       out_ready_i,
    input wire logic       ts_valid_o
);
    localparam int QMAX = PPS_TIMEOUT + 8;
    logic [7:0] last_r, last_nxt;
    int         quiet_r, quiet_nxt;
    logic       pin_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence take_s;
        out_valid_o && out_ready_i;
    endsequence

    // last char taken; quiet counts cycles since a pulse edge at the pin
    always_comb begin
        last_nxt  = (out_valid_o && out_ready_i) ? out_char_o : last_r;
        quiet_nxt = (pulse_per_second_input_i && !pin_r) ? 0 : (quiet_r < QMAX) ? quiet_r + 1 : quiet_r;
    end

    // starts at LF so the first line must open properly
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            last_r  <= CH_LF;
            quiet_r <= QMAX;
            pin_r   <= 1'b0;
        end else begin
            last_r  <= last_nxt;
            quiet_r <= quiet_nxt;
            pin_r   <= pulse_per_second_input_i;
        end
    end

    hold_until_taken_a: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_char_o))
        else $error("output char dropped before taken");
    line_opens_star_a: assert property ((take_s ##0 last_r == CH_LF) |-> out_char_o == CH_STAR)
        else $error("line does not open with star");
    star_then_hex_a: assert property ((take_s ##0 last_r == CH_STAR) |-> out_char_o inside {[8'h30:8'h39], [8'h41:8'h46]})
        else $error("payload not hex after star");
    semi_then_open_a: assert property ((take_s ##0 last_r == CH_SEMI) |-> out_char_o == CH_OPEN)
        else $error("trailer does not follow semicolon");
    close_then_cr_a: assert property ((take_s ##0 last_r == CH_CLOSE) |-> out_char_o == CH_CR)
        else $error("no CR after trailer");
    cr_then_lf_a: assert property ((take_s ##0 last_r == CH_CR) |-> out_char_o == CH_LF)
        else $error("no LF after CR");
    no_lower_a: assert property (take_s |-> !(out_char_o inside {[8'h61:8'h7A]}))
        else $error("lower case char emitted");
    byte_once_a: assert property (in_valid_i && in_ready_o |=> !in_ready_o)
        else $error("ready held after a take");
    ts_live_a: assert property ($rose(pulse_per_second_input_i) |-> ##[1:10] ts_valid_o)
        else $error("timestamps not live after pulse");
    ts_dead_a: assert property (quiet_r == QMAX |-> !ts_valid_o)
        else $error("timestamps live without pulse");
endmodule : rftf_checker

//--- tb/rftf_host_model.sv
`timescale 1ns/1ns
module rftf_host_model
    import rftf_pkg::*;
#(
    parameter int LINE_MAX = 1250
) (
    input wire logic       clk_i,
    input wire logic       rst_b_i,
    input wire logic [7:0] char_i,
    input wire logic       valid_i,
    input wire logic       hold_i,
    input wire logic       slow_i,
    output logic           ready_o,
    output logic           overflow_o
);
    int   seed   = 55;
    int   line_n = 0;
    logic rdy_r  = 1'b0;
    logic ovf_r  = 1'b0;

    // one driver per output, the registers below
    assign ready_o    = rdy_r;
    assign overflow_o = ovf_r;

    // ready moves at the falling edge; random stalls back up the buffer
    always @(negedge clk_i) begin
        rdy_r <= !hold_i && (!slow_i || $random(seed) % 3 != 0);
    end

    // line buffer sized for the longest uplink line
    // pulse timestamps kept raw, calibration scaling left to software above
    always @(posedge clk_i) begin
        if (rst_b_i && valid_i && rdy_r) begin
            line_n = (char_i == CH_LF) ? 0 : line_n + 1;
            if (line_n > LINE_MAX) begin
                ovf_r <= 1'b1;
            end
        end
    end
endmodule : rftf_host_model

//--- tb/rftf_formatter_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module rftf_formatter_tb_top;
    import rftf_pkg::*;
    localparam int         PPS_T = 200;
    localparam int         PPS_PER = 100;
    localparam logic [8:0] WILD  = 9'h100;
    localparam int         NB[4] = '{7, 14, 2, 48};
    localparam int         SS[4] = '{-128, 127, 0, -70};
    localparam int         SQ[4] = '{255, 0, 6, 3};
    logic       clk_i = 0, rst_b_i = 0, in_valid_i = 0, pps = 0, mid_z = 0, hold = 0, slow = 0, pps_on = 0;
    logic       out_ready_i, in_ready_o, out_valid_o, ts_valid_o, ovf;
    logic [7:0] out_char_o, wc;
    logic [8:0] e;
    logic [8:0] exp_q[$];
    rftf_byte_t in_byte_i = '0, sb;
    int         n_mismatch = 0, comparisons = 0, seed = 55, pc = 0, wn = 0, i;
    logic [47:0] wv    = 48'h0;
    logic        wk    = 1'b0;
    time         t_mid = 0;

    always #20 clk_i = ~clk_i;

    rftf_formatter #(.PPS_TIMEOUT(PPS_T)) rftf_formatter_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .in_byte_i(in_byte_i), .in_valid_i(in_valid_i),
        .in_ready_o(in_ready_o), .pulse_per_second_input_i(pps), .midnight_zero_i(mid_z),
        .out_char_o(out_char_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .ts_valid_o(ts_valid_o));

    rftf_host_model rftf_host_model_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .char_i(out_char_o), .valid_i(out_valid_o),
        .hold_i(hold), .slow_i(slow), .ready_o(out_ready_i), .overflow_o(ovf));

    // pulse every 100 cycles, well inside the timeout
    always @(negedge clk_i) begin
        pc  <= pc + 1;
        pps <= pps_on && (pc % PPS_PER < 5);
    end

    task print_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    task push(input logic [7:0] c);
        exp_q.push_back({1'b0, c});
    endtask : push

    // upper-case hex digits of a byte, high nibble first
    task push_hex(input logic [7:0] b);
        push(b[7:4] < 10 ? 8'h30 + b[7:4] : 8'h37 + b[7:4]);
        push(b[3:0] < 10 ? 8'h30 + b[3:0] : 8'h37 + b[3:0]);
    endtask : push_hex

    // decimal without padding, minus only when negative
    task automatic push_dec(input int v);
        int d[$];
        if (v < 0) push(CH_MINUS);
        if (v < 0) v = -v;
        do begin
            d.push_front(v % 10);
            v = v / 10;
        end while (v > 0);
        foreach (d[k]) push(8'(8'h30 + d[k]));
    endtask : push_dec

    // hold the byte until ready is seen, bounded
    task send(input rftf_byte_t b);
        int k;
        in_byte_i  = b;
        in_valid_i = 1'b1;
        for (k = 0; k < 3000 && in_ready_o !== 1'b1; k++) @(negedge clk_i);
        if (k == 3000) begin
            n_mismatch++;
            print_verdict();
        end
        @(negedge clk_i);
    endtask : send

    task frame(input rftf_kind_t k, input int n, input int ss, input int sq, input logic ts);
        rftf_byte_t b;
        @(negedge clk_i);
        `CHK(ts_valid_o, ts)
        push(CH_STAR);
        b = '0;
        b.hdr.kind = k;
        b.hdr.signal_strength_field = 8'(ss);
        b.hdr.signal_quality_field = 8'(sq);
        for (int j = 0; j < n; j++) begin
            b.data  = 8'($random(seed));
            b.first = (j == 0);
            b.last  = (k == RFTF_UAT) ? (j == n - 1) : 1'($random(seed));
            push_hex(k == RFTF_AC ? b.data & AC_OCTAL_MASK : b.data);
            send(b);
        end
        push(CH_SEMI);
        push(CH_OPEN);
        push_dec(ss);
        push(CH_COMMA);
        push_dec(sq);
        push(CH_COMMA);
        if (ts) exp_q.push_back(WILD);
        if (k != RFTF_UAT) begin
            push(CH_COMMA);
            if (ts) exp_q.push_back(WILD);
        end
        push(CH_CLOSE);
        push(CH_CR);
        push(CH_LF);
        in_valid_i = 1'b0;
    endtask : frame

    // oldest note against each char the sink takes; WILD eats a hex number
    always @(posedge clk_i) begin
        if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK(out_valid_o, 1'b0)
            end else if (exp_q[0] == WILD && out_char_o inside {[8'h30:8'h39], [8'h41:8'h46]}) begin
                `CHK(wn == 1 && wc == CH_ZERO, 1'b0)
                wc = (wn == 0) ? out_char_o : wc;
                wv = {wv[43:0], out_char_o[3:0] + (out_char_o[6] ? 4'h9 : 4'h0)};
                wn++;
            end else begin
                // first number since pulse, second since the midnight strobe
                if (exp_q[0] == WILD) begin
                    `CHK(wn != 0, 1'b1)
                    `CHK(wv % CLK_NS, 0)
                    if (!wk) `CHK(wv < 48'(PPS_PER * CLK_NS), 1'b1)
                    else `CHK(wv < $time - t_mid, 1'b1)
                    wk = 1'b1;
                    wn = 0;
                    wv = 48'h0;
                    void'(exp_q.pop_front());
                end
                e = exp_q.pop_front();
                `CHK(out_char_o, e[7:0])
                if (e[7:0] == CH_LF) wk = 1'b0;
            end
        end
    end

    initial begin
        repeat (6) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (4) @(negedge clk_i);
        // stray mid-frame byte while idle must vanish
        sb = '0;
        sb.data = 8'hA5;
        send(sb);
        in_valid_i = 1'b0;
        slow = 1'b1;
        for (i = 0; i < 4; i++) frame(rftf_kind_t'(i), NB[i], SS[i], SQ[i], 1'b0);
        frame(RFTF_UAT, 600, -1, 1, 1'b0);
        pps_on = 1'b1;
        repeat (300) @(negedge clk_i);
        mid_z = 1'b1;
        t_mid = $time;
        @(negedge clk_i);
        mid_z = 1'b0;
        for (i = 0; i < 4; i++) frame(rftf_kind_t'(i), NB[i], SS[i], SQ[i], 1'b1);
        // sink halts long enough to fill the two-entry buffer
        fork
            frame(RFTF_LONG, 14, -95, 2, 1'b1);
            begin
                hold = 1'b1;
                repeat (150) @(negedge clk_i);
                `CHK(in_ready_o, 1'b0)
                hold = 1'b0;
            end
        join
        pps_on = 1'b0;
        repeat (400) @(negedge clk_i);
        frame(RFTF_SHORT, 7, -70, 3, 1'b0);
        for (i = 0; i < 50000 && exp_q.size() != 0; i++) @(negedge clk_i);
        `CHK(exp_q.size(), 0)
        `CHK(ovf, 1'b0)
        print_verdict();
    end
endmodule : rftf_formatter_tb_top

bind rftf_formatter rftf_checker #(.PPS_TIMEOUT(PPS_TIMEOUT)) rftf_checker_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
    .pulse_per_second_input_i(pulse_per_second_input_i), .out_char_o(out_char_o),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .ts_valid_o(ts_valid_o));
